/* rtl/fwpwc_ctrl.sv */
// Notes on behaviour
// (RULE_01) Above 8 MHz main clock, each nonvolatile access waits the configured wait states.
// (RULE_02) Reads and writes need no erase, preparation or unlock; only write locks gate writes.
// (RULE_03) The array is unsegmented; a write changes only the addressed, byte-enabled bits.
// (RULE_04) Every read is followed by a hidden writeback of the sensed value to the same word.
// (RULE_05) A writeback in progress always completes, even when supply power fails.
// (RULE_06) The program-region lock suppresses writes to the main program area.
// (RULE_07) The data-region lock suppresses writes to the information window 1800h to 19FFh.
// (RULE_08) A config write takes effect only when its upper byte equals the password 0xa5.
// (RULE_09) The config password check is a build-time option.
// (RULE_10) Without information memory, the data-region lock has no effect.
// (RULE_11) A write to a locked region is dropped silently, with no interrupt or reset; the code sets the blocked flag in the access status register.
// (RULE_12) Software sets the wait-state count before raising the main clock above 8 MHz.
// (RULE_13) Software keeps the locks on except briefly around an intended write.
// (RULE_14) Vectors and signatures sit at FF80h to FFFFh, writable under the optional lock.
// (RULE_15) The locks affect writes only; reads and their writeback run normally.
// (RULE_16) The controller control register updates only with its own password byte.
`timescale 1ns/10ps
module fwpwc_ctrl
  import fwpwc_pkg::*;
#(
  parameter bit CHECK_PASSWORD = 1'b1,
  parameter bit HAS_INFO_MEM   = 1'b1
)
(
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  PADDR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WE,
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic [1:0]  MEM_BE,
  input  wire logic [15:0] MEM_WDATA,
  output logic      [15:0] MEM_RDATA,
  output logic             MEM_READY,
  input  wire logic        PWR_FAIL
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SENSE,
    ST_RESTORE,
    ST_PROGRAM,
    ST_DONE
  } fwpwc_state_type;

  // ==========================================================================
  // Decoding shared by the access path and the lock check
  function automatic fwpwc_region_type region_of(input logic [15:0] addr);
    if (addr >= PROGRAM_LO)
      region_of = REGION_PROGRAM;
    else if (HAS_INFO_MEM && addr >= INFO_LO && addr <= INFO_HI)
      region_of = REGION_INFO;
    else
      region_of = REGION_NONE;
  endfunction

  function automatic logic [INDEX_W-1:0] index_of(input logic [15:0] addr);
    logic [15:0] off;
    off = 16'h0000;
    if (addr >= PROGRAM_LO)
      off = (addr - PROGRAM_LO) >> 1;
    else
      off = ((addr - INFO_LO) >> 1) + 16'(PROGRAM_WORDS);
    index_of = off[INDEX_W-1:0];
  endfunction

  fwpwc_state_type         state_q;
  logic                    program_lock_q;
  logic                    data_lock_q;
  logic [WAIT_COUNT_W-1:0] wait_count_q;
  logic                    fast_clock_q;
  logic                    blocked_q;
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic [15:0]             mem_rdata_q;
  logic                    mem_ready_q;
  logic                    pwr_meta_q;
  logic                    pwr_fail_q;
  logic                    we_q;
  logic [15:0]             addr_q;
  logic [1:0]              be_q;
  logic [15:0]             wdata_q;
  fwpwc_region_type        region_q;
  logic                    timer_start;
  logic                    timer_done;
  logic                    take_req;
  logic                    write_locked;
  logic                    apb_access;
  logic                    apb_write;
  logic                    cfg_pw_ok;
  logic                    ctl_pw_ok;
  logic                    blocked_set;
  logic                    blocked_clr;
  logic                    mapped;

  fwpwc_array_if arr ();

  assign PRDATA    = prdata_q;
  assign PREADY    = pready_q;
  assign PSLVERR   = pslverr_q;
  assign MEM_RDATA = mem_rdata_q;
  assign MEM_READY = mem_ready_q;

  // ==========================================================================
  // Power-fail pin synchroniser
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      pwr_meta_q <= 1'b0;
      pwr_fail_q <= 1'b0;
    end
    else
    begin
      pwr_meta_q <= PWR_FAIL;
      pwr_fail_q <= pwr_meta_q;
    end
  end

  // ==========================================================================
  // APB decode
  assign apb_access = PSEL && PENABLE && !pready_q;
  assign apb_write  = apb_access && PWRITE;
  assign cfg_pw_ok  = !CHECK_PASSWORD || (PWDATA[PASSWORD_LSB+:8] == CONFIG_PASSWORD); // [RULE_08] [RULE_09]
  assign ctl_pw_ok  = PWDATA[PASSWORD_LSB+:8] == CONTROLLER_PASSWORD;                  // [RULE_16]
  assign mapped     = PADDR == OFS_CONFIG_PROTECT || PADDR == OFS_CONTROLLER_CTRL ||
                      PADDR == OFS_CLOCK_MODE || PADDR == OFS_ACCESS_STATUS;

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= apb_access;
      pslverr_q <= apb_access && !mapped;
      prdata_q  <= 32'h0000_0000;
      if (apb_access && !PWRITE)
      begin
        unique case (PADDR)
          OFS_CONFIG_PROTECT:
          begin
            prdata_q[PROGRAM_LOCK_BIT] <= program_lock_q;
            prdata_q[DATA_LOCK_BIT]    <= data_lock_q;
          end
          OFS_CONTROLLER_CTRL:
          begin
            prdata_q[WAIT_COUNT_LSB+:WAIT_COUNT_W] <= wait_count_q;
          end
          OFS_CLOCK_MODE:
          begin
            prdata_q[FAST_CLOCK_BIT] <= fast_clock_q;
          end
          OFS_ACCESS_STATUS:
          begin
            prdata_q[STAT_BUSY_BIT]      <= state_q != ST_IDLE;
            prdata_q[STAT_BLOCKED_BIT]   <= blocked_q;
            prdata_q[STAT_PWR_FAIL_BIT]  <= pwr_fail_q;
            prdata_q[STAT_WRITEBACK_BIT] <= state_q == ST_RESTORE;
          end
          default:
          begin
            prdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Write locks
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      program_lock_q <= PROGRAM_LOCK_RESET;
      data_lock_q    <= HAS_INFO_MEM ? DATA_LOCK_RESET : 1'b0;
    end
    else if (apb_write && PADDR == OFS_CONFIG_PROTECT && cfg_pw_ok) // [RULE_08]
    begin
      program_lock_q <= PWDATA[PROGRAM_LOCK_BIT];                   // [RULE_06]
      data_lock_q    <= HAS_INFO_MEM && PWDATA[DATA_LOCK_BIT];      // [RULE_07] [RULE_10]
    end
  end

  // ==========================================================================
  // Wait-state count and clock mode
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      wait_count_q <= WAIT_COUNT_RESET;
      fast_clock_q <= FAST_CLOCK_RESET;
    end
    else
    begin
      if (apb_write && PADDR == OFS_CONTROLLER_CTRL && ctl_pw_ok) // [RULE_16]
        wait_count_q <= PWDATA[WAIT_COUNT_LSB+:WAIT_COUNT_W];
      if (apb_write && PADDR == OFS_CLOCK_MODE)
        fast_clock_q <= PWDATA[FAST_CLOCK_BIT];
    end
  end

  // ==========================================================================
  // Blocked-write flag: write one to clear, a new block wins
  assign blocked_set = state_q == ST_PROGRAM && write_locked;
  assign blocked_clr = apb_write && PADDR == OFS_ACCESS_STATUS && PWDATA[STAT_BLOCKED_BIT];

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      blocked_q <= 1'b0;
    else if (blocked_set)
      blocked_q <= 1'b1;
    else if (blocked_clr)
      blocked_q <= 1'b0;
  end

  // ==========================================================================
  // Memory access sequencer
  assign take_req     = state_q == ST_IDLE && MEM_REQ && !mem_ready_q && !pwr_fail_q;
  assign timer_start  = take_req && region_of(MEM_ADDR) != REGION_NONE;
  // Vector area lies inside the program region and shares its lock
  assign write_locked = (region_q == REGION_PROGRAM && program_lock_q) ||   // [RULE_06] [RULE_14]
                        (region_q == REGION_INFO && data_lock_q);           // [RULE_07]

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      state_q  <= ST_IDLE;
      we_q     <= 1'b0;
      addr_q   <= 16'h0000;
      be_q     <= 2'h0;
      wdata_q  <= 16'h0000;
      region_q <= REGION_NONE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (take_req)                                     // [RULE_02]
          begin
            we_q     <= MEM_WE;
            addr_q   <= MEM_ADDR;
            be_q     <= MEM_BE;
            wdata_q  <= MEM_WDATA;
            region_q <= region_of(MEM_ADDR);
            state_q  <= timer_start ? ST_WAIT : ST_DONE;
          end
        end
        ST_WAIT:
        begin
          if (timer_done)
            state_q <= we_q ? ST_PROGRAM : ST_SENSE;        // [RULE_15]
        end
        ST_SENSE:
        begin
          state_q <= ST_RESTORE;                            // [RULE_04]
        end
        ST_RESTORE:
        begin
          state_q <= ST_DONE;                               // [RULE_05]
        end
        ST_PROGRAM:
        begin
          state_q <= ST_DONE;                               // [RULE_11]
        end
        ST_DONE:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Answer to the core
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      mem_ready_q <= 1'b0;
      mem_rdata_q <= 16'h0000;
    end
    else
    begin
      mem_ready_q <= state_q == ST_DONE;
      if (take_req)
        mem_rdata_q <= 16'h0000;
      else if (state_q == ST_RESTORE)
        mem_rdata_q <= arr.rdata;                           // [RULE_15]
    end
  end

  // ==========================================================================
  // Array strobes
  always_comb
  begin
    arr.sense   = state_q == ST_SENSE;
    arr.restore = state_q == ST_RESTORE;                     // [RULE_04] [RULE_05]
    arr.store   = state_q == ST_PROGRAM && !write_locked;    // [RULE_11]
    arr.index   = index_of(addr_q);
    arr.wdata   = arr.restore ? arr.rdata : wdata_q;
    arr.wmask   = {{8{be_q[1]}}, {8{be_q[0]}}};              // [RULE_03]
  end

  fwpwc_wait_timer u_wait_timer
  (
    .clk   (REF_CLK),
    .srst  (SRST),
    .start (timer_start),
    .count (fast_clock_q ? wait_count_q : WAIT_COUNT_RESET), // [RULE_01] [RULE_12]
    .done  (timer_done)
  );

  fwpwc_cell_array u_cell_array
  (
    .clk  (REF_CLK),
    .port (arr.array)
  );

endmodule

/* rtl/fwpwc_pkg.sv */
package fwpwc_pkg;

  // ==========================================================================
  // Register map (APB byte addresses)
  localparam logic [7:0]  OFS_CONFIG_PROTECT   = 8'h00;
  localparam logic [7:0]  OFS_CONTROLLER_CTRL  = 8'h04;
  localparam logic [7:0]  OFS_CLOCK_MODE       = 8'h08;
  localparam logic [7:0]  OFS_ACCESS_STATUS    = 8'h0c;

  // ==========================================================================
  // Field positions
  localparam int PROGRAM_LOCK_BIT   = 0;
  localparam int DATA_LOCK_BIT      = 1;
  localparam int PASSWORD_LSB       = 8;
  localparam int WAIT_COUNT_LSB     = 4;
  localparam int WAIT_COUNT_W       = 3;
  localparam int FAST_CLOCK_BIT     = 0;
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_BLOCKED_BIT   = 1;
  localparam int STAT_PWR_FAIL_BIT  = 2;
  localparam int STAT_WRITEBACK_BIT = 3;

  // ==========================================================================
  // Passwords and reset values
  localparam logic [7:0]  CONFIG_PASSWORD     = 8'ha5;
  localparam logic [7:0]  CONTROLLER_PASSWORD = 8'ha5;
  localparam logic        PROGRAM_LOCK_RESET  = 1'h1;
  localparam logic        DATA_LOCK_RESET     = 1'h1;
  localparam logic [2:0]  WAIT_COUNT_RESET    = 3'h0;
  localparam logic        FAST_CLOCK_RESET    = 1'h0;

  // Main clock above this rate needs wait states (value of fast_clock bit)
  localparam int          NOWAIT_MAX_FREQ_HZ  = 8000000;

  // ==========================================================================
  // Nonvolatile address map
  localparam logic [15:0] PROGRAM_LO   = 16'hc400;
  localparam logic [15:0] PROGRAM_HI   = 16'hffff;
  localparam logic [15:0] INFO_LO      = 16'h1800;
  localparam logic [15:0] INFO_HI      = 16'h19ff;
  localparam logic [15:0] VECTORS_LO   = 16'hff80;
  localparam int          PROGRAM_WORDS = 7680;
  localparam int          INFO_WORDS    = 256;
  localparam int          NVM_WORDS     = PROGRAM_WORDS + INFO_WORDS;
  localparam int          INDEX_W       = 13;

  typedef enum logic [1:0] {
    REGION_NONE,
    REGION_PROGRAM,
    REGION_INFO
  } fwpwc_region_type;

endpackage

/* rtl/fwpwc_array_if.sv */
`timescale 1ns/10ps
interface fwpwc_array_if;
  import fwpwc_pkg::*;

  logic               sense;
  logic               restore;
  logic               store;
  logic [INDEX_W-1:0] index;
  logic [15:0]        wdata;
  logic [15:0]        wmask;
  logic [15:0]        rdata;

  modport ctrl
  (
    output sense,
    output restore,
    output store,
    output index,
    output wdata,
    output wmask,
    input  rdata
  );

  modport array
  (
    input  sense,
    input  restore,
    input  store,
    input  index,
    input  wdata,
    input  wmask,
    output rdata
  );

endinterface

/* rtl/fwpwc_cell_array.sv */
`timescale 1ns/10ps
module fwpwc_cell_array
  import fwpwc_pkg::*;
(
  input wire logic    clk,
  fwpwc_array_if.array port
);

  logic [15:0] mem_q [NVM_WORDS];
  logic [15:0] rdata_q;

  assign port.rdata = rdata_q;

  // ==========================================================================
  // Cell storage: sensing clears the word, so restore must follow
  always_ff @(posedge clk)
  begin
    if (port.sense)
    begin
      rdata_q           <= mem_q[port.index];
      mem_q[port.index] <= 16'h0000;
    end
    else if (port.restore)
    begin
      mem_q[port.index] <= port.wdata;
    end
    else if (port.store)
    begin
      mem_q[port.index] <= (mem_q[port.index] & ~port.wmask) | (port.wdata & port.wmask);
    end
  end

endmodule

/* rtl/fwpwc_wait_timer.sv */
`timescale 1ns/10ps
module fwpwc_wait_timer
  import fwpwc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    start,
  input  wire logic [WAIT_COUNT_W-1:0] count,
  output logic                         done
);

  logic [WAIT_COUNT_W-1:0] cnt_q;
  logic                    run_q;
  logic                    done_q;

  assign done = done_q;

  // ==========================================================================
  // Counts the wait states, then pulses done for one cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        cnt_q <= count;
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        if (cnt_q == '0)
        begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule

/* tb/fwpwc_ctrl_asserts.sv */
`timescale 1ns/10ps
module fwpwc_ctrl_asserts
  import fwpwc_pkg::*;
#(
  parameter bit CHECK_PASSWORD = 1'b1,
  parameter bit HAS_INFO_MEM   = 1'b1
)
(
  input wire logic        REF_CLK,
  input wire logic        SRST,
  input wire logic [7:0]  PADDR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        MEM_REQ,
  input wire logic        MEM_WE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic        MEM_READY,
  input wire logic        PWR_FAIL
);
  logic [1:0] lk_q;
  logic [2:0] wn_q;
  logic [3:0] cnt_q;
  logic [3:0] lat_q;
  logic [3:0] lat_d;
  logic       fast_q;
  logic       pf1_q;
  logic       pf2_q;
  logic       busy_q;
  logic       apb_wr;
  logic       take;
  logic       nvm;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  // ==========================================================================
  // Shadow of register writes and of the access sequencer
  assign apb_wr = PSEL && PENABLE && !PREADY && PWRITE;
  assign take   = MEM_REQ && !busy_q && !MEM_READY && !pf2_q;
  assign nvm    = MEM_ADDR >= PROGRAM_LO
                  || (HAS_INFO_MEM && MEM_ADDR >= INFO_LO && MEM_ADDR <= INFO_HI);
  assign lat_d  = !nvm ? 4'h1 : (MEM_WE ? 4'h4 : 4'h5) + (fast_q ? {1'b0, wn_q} : 4'h0);

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      lk_q   <= {HAS_INFO_MEM, 1'b1};
      wn_q   <= WAIT_COUNT_RESET;
      fast_q <= FAST_CLOCK_RESET;
    end
    else if (apb_wr)
    begin
      if (PADDR == OFS_CONFIG_PROTECT
          && (!CHECK_PASSWORD || PWDATA[15:8] == CONFIG_PASSWORD))
        lk_q <= {PWDATA[1] & HAS_INFO_MEM, PWDATA[0]};
      if (PADDR == OFS_CONTROLLER_CTRL && PWDATA[15:8] == CONTROLLER_PASSWORD)
        wn_q <= PWDATA[6:4];
      if (PADDR == OFS_CLOCK_MODE)
        fast_q <= PWDATA[0];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    pf1_q  <= !SRST && PWR_FAIL;
    pf2_q  <= !SRST && pf1_q;
    busy_q <= !SRST && (take || (busy_q && !MEM_READY));
    cnt_q  <= take ? 4'h0 : cnt_q + 4'h1;
    lat_q  <= take ? lat_d : lat_q;
  end

  // ==========================================================================
  // Properties
  property p_lat; busy_q |-> MEM_READY == (cnt_q == lat_q); endproperty
  a_lat: assert property (p_lat) else $error("memory latency wrong");
  property p_quiet; !busy_q |-> !MEM_READY; endproperty
  a_quiet: assert property (p_quiet) else $error("stray memory completion");
  property p_stall; MEM_REQ && pf2_q && !busy_q |=> !MEM_READY [*2]; endproperty
  a_stall: assert property (p_stall) else $error("request taken in power fail");
  property p_pfdone; busy_q && PWR_FAIL |-> ##[0:12] MEM_READY; endproperty
  a_pfdone: assert property (p_pfdone) else $error("access cut by power fail");
  property p_pready; PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY; endproperty
  a_pready: assert property (p_pready) else $error("register access not answered");
  property p_lock;
    PREADY && !PWRITE && PADDR == OFS_CONFIG_PROTECT |-> PRDATA == {30'h0, lk_q};
  endproperty
  a_lock: assert property (p_lock) else $error("lock bits wrong");
  property p_wait;
    PREADY && !PWRITE && PADDR == OFS_CONTROLLER_CTRL |-> PRDATA == {25'h0, wn_q, 4'h0};
  endproperty
  a_wait: assert property (p_wait) else $error("wait count wrong");
  property p_clock;
    PREADY && !PWRITE && PADDR == OFS_CLOCK_MODE |-> PRDATA == {31'h0, fast_q};
  endproperty
  a_clock: assert property (p_clock) else $error("clock mode wrong");
endmodule

bind fwpwc_ctrl fwpwc_ctrl_asserts #(
  .CHECK_PASSWORD(CHECK_PASSWORD),
  .HAS_INFO_MEM  (HAS_INFO_MEM)
) i_fwpwc_ctrl_asserts (
  .REF_CLK(REF_CLK), .SRST(SRST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_READY(MEM_READY),
  .PWR_FAIL(PWR_FAIL)
);

/* tb/fwpwc_core_model.sv */
`timescale 1ns/10ps
module fwpwc_core_model
  import fwpwc_pkg::*;
(
  input  wire logic        clk,
  output logic             req,
  output logic             we,
  output logic [15:0]      addr,
  output logic [1:0]       be,
  output logic [15:0]      wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        ready
);
  // ==========================================================================
  // Core side: request held until the completion pulse is sampled
  initial
  begin
    req   = 1'b0;
    we    = 1'b0;
    addr  = 16'h0;
    be    = 2'h0;
    wdata = 16'h0;
  end

  task automatic access(input logic w, input logic [15:0] a, input logic [1:0] b,
                        input logic [15:0] d, output logic [15:0] q, output logic ok);
    int n;
    @(posedge clk);
    req   <= 1'b1;
    we    <= w;
    addr  <= a;
    be    <= b;
    wdata <= d;
    n = 0;
    do @(posedge clk); while (ready !== 1'b1 && ++n < 100);
    ok = (ready === 1'b1);
    q  = rdata;
    // Released lines flip so a stale value never looks fresh
    req   <= 1'b0;
    we    <= !w;
    addr  <= ~a;
    be    <= ~b;
    wdata <= ~d;
  endtask
endmodule

/* tb/tb_fwpwc_ctrl.sv */
`timescale 1ns/10ps
module tb_fwpwc_ctrl
  import fwpwc_pkg::*;
;
  logic        REF_CLK = 1'b0;
  logic        SRST = 1'b1;
  logic [7:0]  PADDR = 8'h0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [31:0] PWDATA = 32'h0;
  logic        PWR_FAIL = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        MEM_REQ;
  logic        MEM_WE;
  logic [15:0] MEM_ADDR;
  logic [1:0]  MEM_BE;
  logic [15:0] MEM_WDATA;
  logic [15:0] MEM_RDATA;
  logic        MEM_READY;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          seed = 32'h005e;
  logic [15:0] mem_m [int];
  logic [1:0]  lk = 2'h3;
  logic [2:0]  wn = 3'h0;
  logic        fast = 1'b0;
  logic        blk = 1'b0;
  logic        err;
  logic [31:0] q;
  logic [31:0] rnd;
  logic [15:0] pool [8] = '{16'hc400, 16'hd2a6, 16'hff80, 16'hfffe,
                            16'h1800, 16'h19fe, 16'h2000, 16'h17fe};

  initial
  begin
    forever #5 REF_CLK = ~REF_CLK;
  end

  fwpwc_ctrl i_fwpwc_ctrl (
    .REF_CLK(REF_CLK), .SRST(SRST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
    .MEM_BE(MEM_BE), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .MEM_READY(MEM_READY), .PWR_FAIL(PWR_FAIL)
  );

  fwpwc_core_model i_fwpwc_core_model (
    .clk(REF_CLK), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR), .be(MEM_BE),
    .wdata(MEM_WDATA), .rdata(MEM_RDATA), .ready(MEM_READY)
  );

  // ==========================================================================
  // Bus tasks and reference model
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do @(posedge REF_CLK); while (PREADY !== 1'b1 && ++n < 20);
    if (PREADY !== 1'b1)
      n_mismatch++;
    q   = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    PWDATA  <= ~d;
    @(posedge REF_CLK);
  endtask

  task automatic cfg(input logic [7:0] p, input logic [1:0] b);
    apb(1'b1, OFS_CONFIG_PROTECT, {16'h0, p, 6'h0, b});
    if (p == CONFIG_PASSWORD)
      lk = b;
  endtask

  task automatic ctl(input logic [7:0] p, input logic [2:0] w);
    apb(1'b1, OFS_CONTROLLER_CTRL, {16'h0, p, 1'h0, w, 4'h0});
    if (p == CONTROLLER_PASSWORD)
      wn = w;
  endtask

  task automatic regs();
    apb(1'b0, OFS_CONFIG_PROTECT, 32'h0);
    chk(q, {30'h0, lk});
    apb(1'b0, OFS_CONTROLLER_CTRL, 32'h0);
    chk(q, {25'h0, wn, 4'h0});
    apb(1'b0, OFS_CLOCK_MODE, 32'h0);
    chk(q, {31'h0, fast});
    apb(1'b0, OFS_ACCESS_STATUS, 32'h0);
    chk({31'h0, q[STAT_BLOCKED_BIT]}, {31'h0, blk});
  endtask

  function automatic int region(input logic [15:0] a);
    return a >= PROGRAM_LO ? 1 : (a >= INFO_LO && a <= INFO_HI) ? 2 : 0;
  endfunction

  task automatic mwr(input logic [15:0] a, input logic [1:0] b, input logic [15:0] d);
    logic [15:0] r;
    logic        ok;
    int          g;
    g = region(a);
    i_fwpwc_core_model.access(1'b1, a, b, d, r, ok);
    chk({31'h0, ok}, 32'h1);
    if (g != 0 && lk[g-1])
      blk = 1'b1;
    else if (g != 0)
      mem_m[a] = {b[1] ? d[15:8] : mem_m[a][15:8], b[0] ? d[7:0] : mem_m[a][7:0]};
  endtask

  task automatic mrd(input logic [15:0] a);
    logic [15:0] r;
    logic        ok;
    i_fwpwc_core_model.access(1'b0, a, 2'h3, 16'h0, r, ok);
    chk({16'h0, r}, {16'h0, (region(a) != 0 ? mem_m[a] : 16'h0)});
    chk({31'h0, ok}, 32'h1);
  endtask

  always @(posedge REF_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    SRST <= 1'b0;
    @(posedge REF_CLK);
    regs();
    apb(1'b0, 8'h10, 32'h0);
    chk({q[30:0], err}, 32'h1);
    $display("test reset_and_map done");
    cfg(8'h5a, 2'h0);
    ctl(8'h00, 3'h5);
    regs();
    cfg(CONFIG_PASSWORD, 2'h0);
    foreach (pool[i])
      mwr(pool[i], 2'h3, 16'h3c5a ^ 16'(i));
    $display("test password_and_fill done");
    repeat (150)
    begin
      rnd = $random(seed);
      case (rnd[2:0])
        3'h0: cfg(rnd[3] ? CONFIG_PASSWORD : rnd[15:8], rnd[5:4]);
        3'h1:
        begin
          ctl((rnd[3] || rnd[7]) ? CONTROLLER_PASSWORD : rnd[15:8], rnd[6:4]);
          apb(1'b1, OFS_CLOCK_MODE, {31'h0, rnd[7]});
          fast = rnd[7];
        end
        3'h2: regs();
        3'h3:
        begin
          apb(1'b1, OFS_ACCESS_STATUS, 32'h2);
          blk = 1'b0;
        end
        3'h4, 3'h5: mrd(pool[rnd[18:16]]);
        default: mwr(pool[rnd[18:16]], rnd[21:20], {rnd[31:24], rnd[14:7]});
      endcase
    end
    $display("test random_traffic done");
    fork
      mrd(pool[0]);
      begin
        repeat (3) @(posedge REF_CLK);
        PWR_FAIL <= 1'b1;
      end
    join
    fork
      mrd(pool[4]);
      begin
        repeat (12) @(posedge REF_CLK);
        chk({31'h0, MEM_READY}, 32'h0);
        PWR_FAIL <= 1'b0;
      end
    join
    mrd(pool[0]);
    cfg(CONFIG_PASSWORD, 2'h3);
    $display("test power_fail done");
    give_verdict();
  end
endmodule
